// ==== psp_defines.vh ====
// Constants for the strobed parallel port block
// Notes on behaviour
// [RULE1] Control 0x80: basic mode, every port output
// [RULE2] Control 0x90: basic mode, first port input
// [RULE3] Strobed mode: two groups, 8+3 lines each
// [RULE4] Strobed data paced by group handshake lines
// [RULE5] First strobed input: lines 7,6 set/reset only
// [RULE6] Bits 7,2,1 set: second port strobed input
// [RULE7] Both strobed: second group has no spares
// [RULE8] Status bit 5: first input latch full
// [RULE9] Status bit 4: first enable, via line 4
// [RULE10] Status bit 3: first request, enable gated
// [RULE11] Status bit 2: second enable, via line 2
// [RULE12] Status bit 1: second input latch full
// [RULE13] Status bit 0: second request, second enable
// [RULE14] Strobe levels never appear in status word
// [RULE15] Status words at offsets 02,06,0A,0E
// [RULE16] Control 0xB0: strobed mode, first port input
// [RULE17] Control 0x09 sets line 4: first enable
// [RULE18] Host polls request and full before reading
// [RULE19] First strobed output: lines 4,5 stay spare
// [RULE20] Status layout differs for output and input
// [RULE21] Basic mode: outputs latched, inputs pass through
// [RULE22] Bit 7 set defines mode, clear sets bits
// [RULE23] Strobe low latches data; read clears full
`ifndef PSP_DEFINES_VH
`define PSP_DEFINES_VH
// ==========================================
// Structure
`define PSP_DATA_W 8
`define PSP_FIFO_DEPTH 16
`define PSP_FIFO_AW 4
`define PSP_PINS_W 96
// ==========================================
// Register offsets within a unit, then each unit's status word address
`define PSP_REG_FIRST 2'h0
`define PSP_REG_SECOND 2'h1
`define PSP_REG_CONFIG 2'h3
`define PSP_STATUS_UNIT_A 4'h2
`define PSP_STATUS_UNIT_B 4'h6
`define PSP_STATUS_UNIT_C 4'hA
`define PSP_STATUS_UNIT_D 4'hE
// ==========================================
// Control word fields
`define PSP_CW_RESET 8'h9B
`define PSP_CW_DEFINE 7
`define PSP_CW_AMODE 6:5
`define PSP_CW_ADIR 4
`define PSP_CW_CUDIR 3
`define PSP_CW_BMODE 2
`define PSP_CW_BDIR 1
`define PSP_CW_CLDIR 0
`define PSP_SR_LINE 3:1
`define PSP_SR_VAL 0
// ==========================================
// Handshake line positions
`define PSP_LN_A_INTR 3
`define PSP_LN_A_STB 4
`define PSP_LN_A_FULL 5
`define PSP_LN_A_ACK 6
`define PSP_LN_A_OBF 7
`define PSP_LN_B_INTR 0
`define PSP_LN_B_FULL 1
`define PSP_LN_B_STB 2
// Set/reset line codes that reach each group's enable
`define PSP_SR_A_IN_INTE 3'h4
`define PSP_SR_A_OUT_INTE 3'h6
`define PSP_SR_B_INTE 3'h2
`endif

// ==== psp_port_unit.v ====
// Strobed parallel port block: four port units and read answer FIFO
`timescale 1ns/1ps
`default_nettype none
`include "psp_defines.vh"

// ==========================================
// Read answer FIFO
module psp_fifo #(
  parameter WIDTH = `PSP_DATA_W,
  parameter DEPTH = `PSP_FIFO_DEPTH,
  parameter AW = `PSP_FIFO_AW
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ==========================================
// Four port units behind one register port
module psp_port_unit (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Register access
  input wire bus_valid,
  output wire bus_ready,
  input wire bus_write,
  input wire [3:0] bus_addr,
  input wire [7:0] bus_wdata,
  // Read answers
  output wire rsp_valid,
  input wire rsp_ready,
  output wire [7:0] rsp_data,
  // Interrupt gating
  input wire global_irq_enable,
  output wire [3:0] irq_pending,
  // First data port pins, 8 per unit
  input wire [31:0] first_data_port_in,
  output wire [31:0] first_data_port_out,
  output wire [31:0] first_data_port_oe_n,
  // Second data port pins
  input wire [31:0] second_data_port_in,
  output wire [31:0] second_data_port_out,
  output wire [31:0] second_data_port_oe_n,
  // Split handshake port pins
  input wire [31:0] split_handshake_port_in,
  output wire [31:0] split_handshake_port_out,
  output wire [31:0] split_handshake_port_oe_n
);
  // ==========================================
  // Helpers
  function [3:0] status_offset;
    input [1:0] unit;
    begin
      case (unit)
        2'h0: status_offset = `PSP_STATUS_UNIT_A;
        2'h1: status_offset = `PSP_STATUS_UNIT_B;
        2'h2: status_offset = `PSP_STATUS_UNIT_C;
        default: status_offset = `PSP_STATUS_UNIT_D;
      endcase
    end
  endfunction

  // Split line whose set/reset command moves a group's enable
  function [2:0] enable_line;
    input second;
    input dir_in;
    begin
      if (second) begin
        enable_line = `PSP_SR_B_INTE;
      end else if (dir_in) begin
        enable_line = `PSP_SR_A_IN_INTE;
      end else begin
        enable_line = `PSP_SR_A_OUT_INTE;
      end
    end
  endfunction

  // Buffer line as seen on the pin: full for input, active-low full for output
  function buffer_view;
    input dir_in;
    input full;
    begin
      buffer_view = dir_in ? full : ~full;
    end
  endfunction

  // ==========================================
  // Pin synchronisers
  // Three stages; a level counts once stages two and three agree
  wire [`PSP_PINS_W-1:0] pin_raw;
  reg [`PSP_PINS_W-1:0] pin_s1;
  reg [`PSP_PINS_W-1:0] pin_s2;
  reg [`PSP_PINS_W-1:0] pin_s3;
  reg [`PSP_PINS_W-1:0] pin_f;

  assign pin_raw = {split_handshake_port_in, second_data_port_in, first_data_port_in};

  always @(posedge clk) begin
    if (reset) begin
      pin_s1 <= {`PSP_PINS_W{1'b1}};
      pin_s2 <= {`PSP_PINS_W{1'b1}};
      pin_s3 <= {`PSP_PINS_W{1'b1}};
      pin_f <= {`PSP_PINS_W{1'b1}};
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
    end
  end

  // ==========================================
  // Bus acceptance
  // Reads are refused while the answer FIFO is full
  wire fifo_in_ready;
  wire take;
  wire [31:0] unit_rd;
  wire [7:0] rd_mux;

  assign bus_ready = bus_write | fifo_in_ready;
  assign take = bus_valid & bus_ready;
  assign rd_mux = unit_rd[{bus_addr[3:2], 3'b000} +: 8];

  psp_fifo #(
    .WIDTH(`PSP_DATA_W),
    .DEPTH(`PSP_FIFO_DEPTH),
    .AW(`PSP_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(bus_valid & ~bus_write),
    .in_ready(fifo_in_ready),
    .in_data(rd_mux),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready),
    .out_data(rsp_data)
  );

  // ==========================================
  // Port units
  genvar u;
  genvar g;
  generate
    for (u = 0; u < 4; u = u + 1) begin : g_unit
      localparam [1:0] UID = u;
      wire [7:0] fa = pin_f[u*8 +: 8];
      wire [7:0] fb = pin_f[32 + u*8 +: 8];
      wire [7:0] fc = pin_f[64 + u*8 +: 8];
      reg [7:0] cw;
      reg [7:0] lat_c;
      reg [7:0] st;
      reg [7:0] pc_out;
      reg [7:0] pc_oe_n;
      reg [7:0] rd;
      reg [7:0] pa_q;
      reg [7:0] pa_oe_q;
      reg [7:0] pb_q;
      reg [7:0] pb_oe_q;
      reg [7:0] pc_q;
      reg [7:0] pc_oe_q;
      reg irq_q;
      wire [1:0] g_strobed;
      wire [1:0] g_dirin;
      wire [1:0] g_full;
      wire [1:0] g_inte;
      wire [1:0] g_intr;
      wire [15:0] g_dlat;
      wire cw_hit = take & bus_write & (bus_addr == {UID, `PSP_REG_CONFIG});
      wire def = cw_hit & bus_wdata[`PSP_CW_DEFINE]; // [RULE22]
      wire sr = cw_hit & ~bus_wdata[`PSP_CW_DEFINE]; // [RULE22]
      wire c_wr = take & bus_write & (bus_addr == status_offset(UID)); // [RULE15]

      // Handshake groups: index 0 pairs with the first port, 1 with the second
      for (g = 0; g < 2; g = g + 1) begin : g_grp
        // Mode two on the first group is handled as strobed mode
        wire strobed = g ? cw[`PSP_CW_BMODE] : |cw[`PSP_CW_AMODE]; // [RULE6] [RULE16]
        wire dir_in = g ? cw[`PSP_CW_BDIR] : cw[`PSP_CW_ADIR]; // [RULE2]
        wire [7:0] pin_d = g ? fb : fa;
        wire hs = g ? fc[`PSP_LN_B_STB] : (dir_in ? fc[`PSP_LN_A_STB] : fc[`PSP_LN_A_ACK]); // [RULE3]
        wire [2:0] inte_line = enable_line(g == 1, dir_in);
        wire [1:0] rid = g ? `PSP_REG_SECOND : `PSP_REG_FIRST;
        wire hit = take & (bus_addr == {UID, rid});
        wire dwr = hit & bus_write;
        wire drd = hit & ~bus_write;
        reg [7:0] dlat;
        reg full;
        reg inte;
        reg intr;
        reg hs_q;
        wire fall = strobed & hs_q & ~hs;
        wire rise = strobed & ~hs_q & hs;

        always @(posedge clk) begin
          if (reset) begin
            dlat <= 8'h00;
            full <= 1'b0;
            inte <= 1'b0;
            intr <= 1'b0;
            hs_q <= 1'b1;
          end else begin
            hs_q <= hs;
            if (def) begin
              dlat <= 8'h00;
              full <= 1'b0;
              inte <= 1'b0;
              intr <= 1'b0;
            end else begin
              if (sr && strobed && bus_wdata[`PSP_SR_LINE] == inte_line) begin
                inte <= bus_wdata[`PSP_SR_VAL]; // [RULE9] [RULE11] [RULE17]
              end
              if (dir_in) begin
                if (fall) begin
                  dlat <= pin_d; // [RULE23]
                end
                // A new strobe wins over a read in the same cycle
                full <= strobed & (fall | (full & ~drd)); // [RULE4] [RULE23]
                intr <= strobed & ((rise & full & inte) | (intr & ~drd)); // [RULE4]
              end else begin
                if (dwr) begin
                  dlat <= bus_wdata; // [RULE21]
                end
                full <= strobed & (dwr | (full & ~fall)); // [RULE4]
                intr <= strobed & ((rise & full & inte) | (intr & ~dwr));
              end
            end
          end
        end

        assign g_strobed[g] = strobed;
        assign g_dirin[g] = dir_in;
        assign g_full[g] = full;
        assign g_inte[g] = inte;
        assign g_intr[g] = intr & inte; // [RULE10] [RULE13]
        assign g_dlat[g*8 +: 8] = dlat;
      end

      // Split port: control word, bit latch and status view
      always @(posedge clk) begin
        if (reset) begin
          cw <= `PSP_CW_RESET;
          lat_c <= 8'h00;
        end else if (def) begin
          cw <= bus_wdata; // [RULE1] [RULE2] [RULE16]
          lat_c <= 8'h00;
        end else if (sr) begin
          lat_c[bus_wdata[`PSP_SR_LINE]] <= bus_wdata[`PSP_SR_VAL]; // [RULE5]
        end else if (c_wr && g_strobed == 2'b00) begin
          // Whole-word writes would upset handshake spares, so strobed mode ignores them
          lat_c <= bus_wdata; // [RULE5] [RULE21]
        end
      end

      always @* begin
        st = {cw[`PSP_CW_CUDIR] ? fc[7:4] : lat_c[7:4], cw[`PSP_CW_CLDIR] ? fc[3:0] : lat_c[3:0]}; // [RULE21]
        pc_out = lat_c;
        pc_oe_n = {{4{cw[`PSP_CW_CUDIR]}}, {4{cw[`PSP_CW_CLDIR]}}}; // [RULE19]
        if (g_strobed[0]) begin
          if (g_dirin[0]) begin
            st[`PSP_LN_A_FULL] = g_full[0]; // [RULE8]
            st[`PSP_LN_A_STB] = g_inte[0]; // [RULE9] [RULE14]
            pc_out[`PSP_LN_A_FULL] = g_full[0];
            pc_oe_n[`PSP_LN_A_FULL] = 1'b0;
            pc_oe_n[`PSP_LN_A_STB] = 1'b1;
          end else begin
            st[`PSP_LN_A_OBF] = ~g_full[0]; // [RULE20]
            st[`PSP_LN_A_ACK] = g_inte[0]; // [RULE20]
            pc_out[`PSP_LN_A_OBF] = ~g_full[0];
            pc_oe_n[`PSP_LN_A_OBF] = 1'b0;
            pc_oe_n[`PSP_LN_A_ACK] = 1'b1;
          end
          st[`PSP_LN_A_INTR] = g_intr[0]; // [RULE10]
          pc_out[`PSP_LN_A_INTR] = g_intr[0];
          pc_oe_n[`PSP_LN_A_INTR] = 1'b0;
        end
        if (g_strobed[1]) begin
          // All three low lines become handshake; line 3 stays spare unless the first group is strobed
          st[`PSP_LN_B_STB] = g_inte[1]; // [RULE7] [RULE11] [RULE14]
          st[`PSP_LN_B_FULL] = buffer_view(g_dirin[1], g_full[1]); // [RULE12] [RULE20]
          st[`PSP_LN_B_INTR] = g_intr[1]; // [RULE13]
          pc_out[`PSP_LN_B_FULL] = buffer_view(g_dirin[1], g_full[1]);
          pc_out[`PSP_LN_B_INTR] = g_intr[1];
          pc_oe_n[`PSP_LN_B_STB] = 1'b1;
          pc_oe_n[`PSP_LN_B_FULL] = 1'b0;
          pc_oe_n[`PSP_LN_B_INTR] = 1'b0;
        end
      end

      always @* begin
        case (bus_addr[1:0])
          `PSP_REG_FIRST: rd = (g_dirin[0] & ~g_strobed[0]) ? fa : g_dlat[7:0]; // [RULE21]
          `PSP_REG_SECOND: rd = (g_dirin[1] & ~g_strobed[1]) ? fb : g_dlat[15:8];
          `PSP_REG_CONFIG: rd = cw;
          default: rd = st; // [RULE15]
        endcase
      end

      // Registered pin drive; an input port is never driven
      always @(posedge clk) begin
        if (reset) begin
          pa_q <= 8'h00;
          pa_oe_q <= 8'hFF;
          pb_q <= 8'h00;
          pb_oe_q <= 8'hFF;
          pc_q <= 8'h00;
          pc_oe_q <= 8'hFF;
          irq_q <= 1'b0;
        end else begin
          pa_q <= g_dlat[7:0];
          pa_oe_q <= {8{g_dirin[0]}}; // [RULE1] [RULE2]
          pb_q <= g_dlat[15:8];
          pb_oe_q <= {8{g_dirin[1]}};
          pc_q <= pc_out;
          pc_oe_q <= pc_oe_n;
          irq_q <= global_irq_enable & (|g_intr); // [RULE10]
        end
      end

      assign unit_rd[u*8 +: 8] = rd;
      assign first_data_port_out[u*8 +: 8] = pa_q;
      assign first_data_port_oe_n[u*8 +: 8] = pa_oe_q;
      assign second_data_port_out[u*8 +: 8] = pb_q;
      assign second_data_port_oe_n[u*8 +: 8] = pb_oe_q;
      assign split_handshake_port_out[u*8 +: 8] = pc_q;
      assign split_handshake_port_oe_n[u*8 +: 8] = pc_oe_q;
      assign irq_pending[u] = irq_q;
    end
  endgenerate
endmodule
`default_nettype wire

// ==== psp_asserts.sv ====
// Port assertions for the strobed parallel port block
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Checker
module psp_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic bus_valid,
  input wire logic bus_ready,
  input wire logic bus_write,
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic rsp_valid,
  // Pins
  input wire logic global_irq_enable,
  input wire logic [3:0] irq_pending,
  input wire logic [31:0] first_data_port_oe_n,
  input wire logic [31:0] second_data_port_oe_n,
  input wire logic [31:0] split_handshake_port_in,
  input wire logic [31:0] split_handshake_port_out,
  input wire logic [31:0] split_handshake_port_oe_n
);
  logic [7:0] cfg;
  wire cw = bus_valid & bus_write & (bus_addr == 4'h3);
  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);
  // Last mode word of unit 0, so plain output lines are not taken for the full line
  always @(posedge clk) begin
    if (reset) cfg <= 8'h9B;
    else if (cw && bus_wdata[7]) cfg <= bus_wdata;
  end
  AST_WR_TAKEN: assert property (bus_valid && bus_write |-> bus_ready)
    else $error("write refused");
  AST_RD_ANSWER: assert property (bus_valid && !bus_write && bus_ready && !rsp_valid |=> rsp_valid)
    else $error("no read answer");
  AST_RESET_STATE: assert property ($fell(reset) |-> &first_data_port_oe_n &&
    &split_handshake_port_oe_n && irq_pending == 4'h0) else $error("bad reset state");
  AST_MODE_80: assert property (cw && bus_wdata == 8'h80 |-> ##2 first_data_port_oe_n[7:0] == 8'h00 &&
    second_data_port_oe_n[7:0] == 8'h00 && split_handshake_port_oe_n[7:0] == 8'h00) else $error("mode 80");
  AST_MODE_90: assert property (cw && bus_wdata == 8'h90 |-> ##2 first_data_port_oe_n[7:0] == 8'hFF &&
    second_data_port_oe_n[7:0] == 8'h00) else $error("mode 90");
  AST_MODE_B0: assert property (cw && bus_wdata == 8'hB0 |-> ##2 first_data_port_oe_n[7:0] == 8'hFF &&
    split_handshake_port_oe_n[5:4] == 2'b01) else $error("mode B0");
  AST_SPARE_LINES: assert property (cw && bus_wdata[7] && bus_wdata[6:5] != 2'b00 && bus_wdata[4] &&
    !bus_wdata[3] |-> ##2 split_handshake_port_oe_n[7:6] == 2'b00) else $error("spare lines");
  AST_SECOND_IN: assert property (cw && bus_wdata[7] && bus_wdata[2] && bus_wdata[1] |=> ##1
    second_data_port_oe_n[7:0] == 8'hFF && split_handshake_port_oe_n[2:1] == 2'b10) else $error("second in");
  AST_FULL_STROBE: assert property (cfg[6:5] != 2'b00 && cfg[4] && $rose(split_handshake_port_out[5])
    |-> !$past(split_handshake_port_in[4], 3)) else $error("full without strobe");
  AST_IRQ_GATED: assert property (irq_pending != 4'h0 |-> $past(global_irq_enable))
    else $error("irq ungated");
endmodule
`default_nettype wire

// ==== psp_far.sv ====
// Far side model: strobes bytes into one input group
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Strobing source
module psp_far (
  // Clock
  input wire logic clk,
  // Group lines
  output logic [7:0] data,
  output logic strobe_n
);
  initial begin
    data = 8'h00;
    strobe_n = 1'b1;
  end
  // Byte set up before a 6 clock low strobe; the filter needs 2
  task put(input logic [7:0] b, input int lag);
    repeat (lag) @(posedge clk);
    data <= b;
    @(posedge clk);
    strobe_n <= 1'b0;
    repeat (6) @(posedge clk);
    strobe_n <= 1'b1;
    @(posedge clk);
    // Released lines show the inverse, never a stale copy
    data <= ~b;
  endtask
endmodule
`default_nettype wire

// ==== test_psp_port_unit.sv ====
// Bench for the strobed parallel port block
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Bench
module test_psp_port_unit;
  typedef struct {logic [7:0] cw, o1, o2, oc;} psp_row_t;
  logic clk, reset, bus_valid, bus_write, rsp_ready, global_irq_enable, sa, sb;
  logic [3:0] bus_addr;
  logic [7:0] bus_wdata, da, db, got, u;
  wire bus_ready, rsp_valid;
  wire [7:0] rsp_data;
  wire [3:0] irq;
  wire [31:0] f_out, f_oe, s_out, s_oe, h_out, h_oe;
  int error_cnt, num_checks, i, k;
  psp_row_t rows[7] = '{'{8'h80, 8'h00, 8'h00, 8'h00}, '{8'h90, 8'hFF, 8'h00, 8'h00},
    '{8'h9B, 8'hFF, 8'hFF, 8'hFF}, '{8'h86, 8'h00, 8'hFF, 8'h04}, '{8'hB0, 8'hFF, 8'h00, 8'h10},
    '{8'hB6, 8'hFF, 8'hFF, 8'h14}, '{8'hA0, 8'h00, 8'h00, 8'h40}};
  psp_far far_a (.clk, .data(da), .strobe_n(sa));
  psp_far far_b (.clk, .data(db), .strobe_n(sb));
  psp_port_unit dut (.clk, .reset, .bus_valid, .bus_ready, .bus_write, .bus_addr, .bus_wdata,
    .rsp_valid, .rsp_ready, .rsp_data, .global_irq_enable, .irq_pending(irq),
    .first_data_port_in({{3{db}}, da}), .first_data_port_out(f_out), .first_data_port_oe_n(f_oe),
    .second_data_port_in({{3{da}}, db}), .second_data_port_out(s_out), .second_data_port_oe_n(s_oe),
    .split_handshake_port_in({{3{db}}, da[7:5], sa, da[3], sb, da[1:0]}),
    .split_handshake_port_out(h_out), .split_handshake_port_oe_n(h_oe));
  task check(input string n, input logic [7:0] s, e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task tmo;
    check("wait", 8'h00, 8'h01);
    wrap_up;
  endtask
  // Ready is looked at mid-cycle, so the taking edge is never raced
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    bus_valid <= 1'b1;
    bus_write <= w;
    bus_addr <= a;
    bus_wdata <= d;
    i = 0;
    @(negedge clk);
    while (bus_ready !== 1'b1) begin
      i++;
      if (i > 40) tmo;
      @(negedge clk);
    end
    @(posedge clk);
    bus_valid <= 1'b0;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    @(posedge clk);
  endtask
  task get(input logic [3:0] a);
    bus(1'b0, a, 8'h00);
    i = 0;
    @(negedge clk);
    while (rsp_valid !== 1'b1) begin
      i++;
      if (i > 40) tmo;
      @(negedge clk);
    end
    got = rsp_data;
    @(posedge clk);
  endtask
  task poll(input logic [7:0] m);
    k = 0;
    get(4'h2);
    while ((got & m) != m) begin
      k++;
      if (k > 60) tmo;
      get(4'h2);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    bus_valid = 1'b0;
    bus_write = 1'b0;
    bus_addr = 4'h0;
    bus_wdata = 8'h00;
    rsp_ready = 1'b1;
    global_irq_enable = 1'b1;
    error_cnt = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check("oec", h_oe[7:0], 8'hFF);
    check("out1", f_out[7:0], 8'h00);
    @(posedge clk);
    foreach (rows[r]) begin
      wr(4'h3, rows[r].cw);
      wr(4'h0, 8'hA5);
      repeat (2) @(negedge clk);
      check("oe1", f_oe[7:0], rows[r].o1);
      check("oe2", s_oe[7:0], rows[r].o2);
      check("oec", h_oe[7:0], rows[r].oc);
      if (rows[r].o1 == 8'h00) check("out1", f_out[7:0], 8'hA5);
      if (rows[r].o2 == 8'h00) check("out2", s_out[7:0], 8'h00);
      @(posedge clk);
    end
    get(4'h2);
    check("stat out", got, 8'h00);
    for (u = 8'h00; u < 8'h04; u++) begin
      wr({u[1:0], 2'b11}, 8'h80);
      wr({u[1:0], 2'b10}, 8'h3C + u);
      get({u[1:0], 2'b10});
      check("stat word", got, 8'h3C + u);
    end
    wr(4'h3, 8'hB0);
    wr(4'h3, 8'h09);
    far_a.put(8'h5A, 0);
    poll(8'h28);
    check("stat a", got, 8'h38);
    @(negedge clk);
    check("irq", {4'h0, irq}, 8'h01);
    check("pin c", h_out[7:0] & ~h_oe[7:0], 8'h28);
    @(posedge clk);
    get(4'h0);
    check("data a", got, 8'h5A);
    get(4'h2);
    check("stat a", got, 8'h10);
    wr(4'h3, 8'h08);
    far_a.put(8'hE1, 5);
    poll(8'h20);
    check("stat a", got, 8'h20);
    wr(4'h3, 8'h0F);
    wr(4'h2, 8'h00);
    get(4'h2);
    check("stat a", got, 8'hA0);
    get(4'h0);
    check("data a", got, 8'hE1);
    wr(4'h3, 8'h86);
    wr(4'h3, 8'h05);
    far_b.put(8'hC3, 3);
    poll(8'h03);
    check("stat b", got, 8'h07);
    get(4'h1);
    check("data b", got, 8'hC3);
    rsp_ready <= 1'b0;
    for (k = 0; k < 16; k++) begin
      bus(1'b0, 4'h3, 8'h00);
      @(posedge clk);
    end
    @(negedge clk);
    check("ready", {7'h00, bus_ready}, 8'h00);
    @(posedge clk);
    rsp_ready <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(negedge clk);
      check("queued", rsp_data, 8'h86);
    end
    @(negedge clk);
    check("drained", {7'h00, rsp_valid}, 8'h00);
    @(posedge clk);
    wr(4'h3, 8'h90);
    get(4'h0);
    check("pins a", got, 8'h1E);
    wrap_up;
  end
endmodule
bind psp_port_unit psp_asserts chk (.clk, .reset, .bus_valid, .bus_ready, .bus_write, .bus_addr,
  .bus_wdata, .rsp_valid, .global_irq_enable, .irq_pending, .first_data_port_oe_n, .second_data_port_oe_n,
  .split_handshake_port_in, .split_handshake_port_out, .split_handshake_port_oe_n);
`default_nettype wire
